// >>> shared/rai_params.svh
// Contract
// - static field 2 selects antenna zero
// - static field resets to three
// - switch enable drives complementary pair; 1 antenna one; fields 0 and 3 drive both pins low
// - control bit 7 enables front-end indicator
// - indicator low/high idle, inverted while transmitting
// - indicator disabled drives both pins low
// - trigger edge when locked starts transmit
// - two lead-time fields shift indicator timing
// - time stamp rises on valid header
// - time stamp high until frame ends
// - unused shared pin driven low
// - bit 4 turns irq into empty flag
// - flag low readable, high not ready
// - flag valid 750 ns after command
// - interrupts held off, shown at deselect
// - other accesses show interrupts only
// - receive error locks flag at empty
`ifndef RAI_PARAMS_SVH
`define RAI_PARAMS_SVH

// register offsets
`define RAI_OFS_CTRL1      6'h04
`define RAI_OFS_LEAD       6'h05
`define RAI_OFS_ANT        6'h0d

// reset values
`define RAI_RST_CTRL1      8'h20
`define RAI_RST_LEAD       8'h00
`define RAI_RST_ANT        4'h3

// field positions
`define RAI_B_FE_EN        7
`define RAI_B_TS_EN        6
`define RAI_B_FBE_EN       4
`define RAI_B_SW_EN        2
`define RAI_B_BUFLT_HI     7
`define RAI_B_BUFLT_LO     6
`define RAI_B_PALT_HI      5
`define RAI_B_PALT_LO      4

// spi command codes
`define RAI_CMD_REG_WR     2'b11
`define RAI_CMD_REG_RD     2'b10
`define RAI_CMD_FB_RD      3'b001

// antenna field codes
`define RAI_ANT_ONE        2'h1
`define RAI_ANT_ZERO       2'h2

// timing
`define RAI_CLK_MHZ        20
`define RAI_SETTLE_US      16
`define RAI_SETTLE_CYC     (`RAI_SETTLE_US * `RAI_CLK_MHZ)
`define RAI_FBE_NS         750
`define RAI_FBE_CYC        ((`RAI_FBE_NS * `RAI_CLK_MHZ + 999) / 1000)
`define RAI_LEAD_STEP_US   2
`define RAI_LEAD_STEP_CYC  (`RAI_LEAD_STEP_US * `RAI_CLK_MHZ)

`endif

// >>> shared/rai_pkg.sv
package rai_pkg;
    // transmit sequencing
    typedef enum logic {
        RAI_TX_IDLE,
        RAI_TX_BUSY
    } rai_tx_state_t;

    typedef logic [7:0] rai_byte_t;
endpackage : rai_pkg

// >>> src/rai_indicator_pins.sv
`timescale 1ns/1ps
`include "rai_params.svh"

module rai_indicator_pins #(
    parameter int SETTLE_CYC = `RAI_SETTLE_CYC,
    parameter int FBE_CYC    = `RAI_FBE_CYC,
    parameter int STEP_CYC   = `RAI_LEAD_STEP_CYC
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // spi slave
    input  wire logic               sclk,
    input  wire logic               sel_n,
    input  wire logic               mosi,
    output logic                    miso,
    output logic                    miso_oe,
    // transceiver core status
    input  wire logic               pll_locked,
    input  wire logic               sleep_transmit_trigger,
    input  wire logic               tx_done,
    input  wire logic               phr_valid,
    input  wire logic               rx_frame_end,
    input  wire logic               rx_error,
    input  wire logic               irq_pending,
    // frame buffer side
    input  wire logic               fb_data_avail,
    input  wire rai_pkg::rai_byte_t fb_byte,
    output logic                    fb_pop,
    // core controls
    output logic                    tx_busy,
    output logic                    mod_start,
    // pins
    output logic                    antenna_switch_out_one,
    output logic                    antenna_switch_out_two,
    output logic                    frontend_indicator_one,
    output logic                    frontend_indicator_two,
    output logic                    irq_pin
);
    import rai_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register state
    rai_byte_t ctrl1_q, ctrl1_d;
    rai_byte_t lead_q, lead_d;
    logic [3:0] ant_q, ant_d;
    logic wr_en;
    logic [5:0] wr_addr;
    rai_byte_t wr_data;
    rai_byte_t rd_data;
    logic [5:0] rd_addr;

    logic frontend_indicator_enable;
    logic rx_timestamp_enable;
    logic buffer_empty_indicator_enable;
    logic antenna_switch_output_enable;
    logic [1:0] static_antenna_select;
    logic [1:0] pa_buffer_lead_time;
    logic [1:0] pa_lead_time;
    logic ant_selected;

    assign frontend_indicator_enable     = ctrl1_q[`RAI_B_FE_EN];
    assign rx_timestamp_enable           = ctrl1_q[`RAI_B_TS_EN];
    assign buffer_empty_indicator_enable = ctrl1_q[`RAI_B_FBE_EN];
    assign antenna_switch_output_enable  = ant_q[`RAI_B_SW_EN];
    assign static_antenna_select         = ant_q[1:0];
    assign pa_buffer_lead_time = lead_q[`RAI_B_BUFLT_HI:`RAI_B_BUFLT_LO];
    assign pa_lead_time        = lead_q[`RAI_B_PALT_HI:`RAI_B_PALT_LO];
    // field value 1 is antenna one, everything else reports antenna zero
    assign ant_selected = (static_antenna_select == `RAI_ANT_ONE);

    // register write decode
    always_comb begin
        ctrl1_d = ctrl1_q;
        lead_d  = lead_q;
        ant_d   = ant_q;
        if (wr_en) begin
            case (wr_addr)
                `RAI_OFS_CTRL1: ctrl1_d = wr_data;
                `RAI_OFS_LEAD:  lead_d  = wr_data;
                `RAI_OFS_ANT:   ant_d   = wr_data[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl1_q <= `RAI_RST_CTRL1;
            lead_q  <= `RAI_RST_LEAD;
            ant_q   <= `RAI_RST_ANT;
        end else begin
            ctrl1_q <= ctrl1_d;
            lead_q  <= lead_d;
            ant_q   <= ant_d;
        end
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        case (rd_addr)
            `RAI_OFS_CTRL1: rd_data = ctrl1_q;
            `RAI_OFS_LEAD:  rd_data = lead_q;
            `RAI_OFS_ANT:   rd_data = {ant_selected, 3'h0, ant_q};
            default:        rd_data = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // spi slave; sclk is oversampled, so it must stay below clk/4
    logic sclk_q;
    logic sclk_rise, sclk_fall;
    logic [2:0] bit_q, bit_d;
    logic first_q, first_d;
    rai_byte_t cmd_q, cmd_d;
    rai_byte_t sh_q, sh_d;
    rai_byte_t out_q, out_d;
    logic load_q, load_d;
    logic fb_rd_q, fb_rd_d;
    logic fbe_q, fbe_d;
    logic err_q, err_d;
    logic [4:0] wait_q, wait_d;
    logic pop_d;
    rai_byte_t full;
    // register value is captured at the command byte for the read
    rai_byte_t rd_data_q;

    assign sclk_rise = sclk & ~sclk_q;
    assign sclk_fall = ~sclk & sclk_q;
    assign full      = {sh_q[6:0], mosi};
    assign rd_addr   = full[5:0];
    assign miso      = out_q[7];
    assign miso_oe   = ~sel_n;

    // byte assembly, command decode and the empty-flag window
    always_comb begin
        bit_d   = bit_q;
        first_d = first_q;
        cmd_d   = cmd_q;
        sh_d    = sh_q;
        out_d   = out_q;
        load_d  = load_q;
        fb_rd_d = fb_rd_q;
        fbe_d   = fbe_q;
        err_d   = err_q;
        wait_d  = wait_q;
        pop_d   = 1'b0;
        wr_en   = 1'b0;
        wr_addr = cmd_q[5:0];
        wr_data = full;
        if (sel_n) begin
            // deselect ends every access and the flag window with it
            bit_d   = 3'h0;
            first_d = 1'b1;
            cmd_d   = 8'h00;
            out_d   = 8'h00;
            load_d  = 1'b0;
            fb_rd_d = 1'b0;
            fbe_d   = 1'b0;
            err_d   = 1'b0;
            wait_d  = 5'h0;
        end else begin
            if (sclk_rise) begin
                sh_d  = full;
                bit_d = bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                    if (first_q) begin
                        first_d = 1'b0;
                        cmd_d   = full;
                        if (full[7:6] == `RAI_CMD_REG_RD) begin
                            load_d = 1'b1;
                        end
                        if (full[7:5] == `RAI_CMD_FB_RD) begin
                            fb_rd_d = 1'b1;
                            load_d  = 1'b1;
                            // window opens after the command byte
                            fbe_d   = buffer_empty_indicator_enable;
                        end
                    end else begin
                        if (cmd_q[7:6] == `RAI_CMD_REG_WR) begin
                            wr_en = 1'b1;
                        end
                        load_d = fb_rd_q;
                    end
                end
            end
            if (sclk_fall) begin
                if (load_q) begin
                    // first bit must stand before the next rising edge
                    out_d  = fb_rd_q ? fb_byte : rd_data_q;
                    pop_d  = fb_rd_q;
                    load_d = 1'b0;
                end else begin
                    out_d = {out_q[6:0], 1'b0};
                end
            end
            if (fbe_q && (wait_q != 5'(FBE_CYC))) begin
                wait_d = wait_q + 5'h1;
            end
            if (fbe_q && rx_error) begin
                err_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_q    <= 1'b0;
            bit_q     <= 3'h0;
            first_q   <= 1'b1;
            cmd_q     <= 8'h00;
            sh_q      <= 8'h00;
            out_q     <= 8'h00;
            load_q    <= 1'b0;
            fb_rd_q   <= 1'b0;
            fbe_q     <= 1'b0;
            err_q     <= 1'b0;
            wait_q    <= 5'h0;
            fb_pop    <= 1'b0;
            rd_data_q <= 8'h00;
        end else begin
            sclk_q    <= sclk;
            bit_q     <= bit_d;
            first_q   <= first_d;
            cmd_q     <= cmd_d;
            sh_q      <= sh_d;
            out_q     <= out_d;
            load_q    <= load_d;
            fb_rd_q   <= fb_rd_d;
            fbe_q     <= fbe_d;
            err_q     <= err_d;
            wait_q    <= wait_d;
            fb_pop    <= pop_d;
            rd_data_q <= (sclk_rise && first_q) ? rd_data : rd_data_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit sequencing
    rai_tx_state_t tx_q, tx_d;
    logic trig_q;
    logic [8:0] cnt_q, cnt_d;
    logic [8:0] lead_cyc;
    logic ind_on;

    // both lead fields pull the indicator ahead of modulation start
    assign lead_cyc = 9'(({1'b0, pa_lead_time} + {1'b0, pa_buffer_lead_time}) * STEP_CYC);

    always_comb begin
        tx_d  = tx_q;
        cnt_d = cnt_q;
        case (tx_q)
            RAI_TX_IDLE: begin
                cnt_d = 9'h0;
                if (sleep_transmit_trigger && !trig_q && pll_locked) begin
                    tx_d = RAI_TX_BUSY;
                end
            end
            RAI_TX_BUSY: begin
                if (cnt_q != 9'(SETTLE_CYC)) begin
                    cnt_d = cnt_q + 9'h1;
                end
                if (tx_done) begin
                    tx_d = RAI_TX_IDLE;
                end
            end
            default: tx_d = RAI_TX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_q      <= RAI_TX_IDLE;
            trig_q    <= 1'b0;
            cnt_q     <= 9'h0;
            mod_start <= 1'b0;
        end else begin
            tx_q      <= tx_d;
            trig_q    <= sleep_transmit_trigger;
            cnt_q     <= cnt_d;
            mod_start <= (tx_q == RAI_TX_BUSY) && (cnt_q == 9'(SETTLE_CYC - 1));
        end
    end

    assign tx_busy = (tx_q == RAI_TX_BUSY);
    // one extra bit: saturated count plus the largest lead would wrap at nine bits
    assign ind_on  = tx_busy && (({1'b0, cnt_q} + {1'b0, lead_cyc}) >= 10'(SETTLE_CYC));

    ////////////////////////////////////////////////////////////////////////
    // pin outputs, all registered from the current state
    logic ts_q, ts_d;
    logic sw1_d, sw2_d, fe1_d, fe2_d, irq_d;
    logic flag;

    // before the 750 ns FBE_CYC wait elapses the flag reads as not ready
    assign flag = (wait_q != 5'(FBE_CYC)) || err_q || !fb_data_avail;

    always_comb begin
        ts_d = ts_q;
        if (rx_frame_end || !rx_timestamp_enable) begin
            ts_d = 1'b0;
        end
        if (phr_valid && rx_timestamp_enable) begin
            ts_d = 1'b1;
        end
        sw1_d = 1'b0;
        sw2_d = 1'b0;
        // switch control takes the shared pin if both are set
        if (antenna_switch_output_enable) begin
            if (static_antenna_select == `RAI_ANT_ZERO) begin
                sw1_d = 1'b1;
            end else if (static_antenna_select == `RAI_ANT_ONE) begin
                sw2_d = 1'b1;
            end
        end else if (rx_timestamp_enable) begin
            sw2_d = ts_q;
        end
        if (frontend_indicator_enable) begin
            fe1_d = ind_on;
            fe2_d = !ind_on;
        end else begin
            fe1_d = 1'b0;
            fe2_d = 1'b0;
        end
        irq_d = fbe_q ? flag : irq_pending;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ts_q                   <= 1'b0;
            antenna_switch_out_one <= 1'b0;
            antenna_switch_out_two <= 1'b0;
            frontend_indicator_one <= 1'b0;
            frontend_indicator_two <= 1'b0;
            irq_pin                <= 1'b0;
        end else begin
            ts_q                   <= ts_d;
            antenna_switch_out_one <= sw1_d;
            antenna_switch_out_two <= sw2_d;
            frontend_indicator_one <= fe1_d;
            frontend_indicator_two <= fe2_d;
            irq_pin                <= irq_d;
        end
    end

endmodule : rai_indicator_pins

// >>> verif/rai_checker.sv
`timescale 1ns/1ps
module rai_checker #(parameter int SETTLE_CYC = 320) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched ports
    input wire logic sel_n,
    input wire logic pll_locked,
    input wire logic sleep_transmit_trigger,
    input wire logic tx_done,
    input wire logic irq_pending,
    input wire logic tx_busy,
    input wire logic mod_start,
    input wire logic antenna_switch_out_one,
    input wire logic antenna_switch_out_two,
    input wire logic frontend_indicator_one,
    input wire logic frontend_indicator_two,
    input wire logic irq_pin
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    ////////////////////////////////////////
    // cycles since transmit entry; zero while idle
    always_comb cnt_d = tx_busy ? cnt_q + 16'h1 : 16'h0;
    always_ff @(posedge clk) cnt_q <= rst ? 16'h0 : cnt_d;
    ////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_SW_PAIR: assert property (!(antenna_switch_out_one && antenna_switch_out_two))
        else $error("antenna pins both high");
    AST_FE_PAIR: assert property (!(frontend_indicator_one && frontend_indicator_two))
        else $error("indicator pins both high");
    AST_FE_TX: assert property (frontend_indicator_one |-> $past(tx_busy))
        else $error("indicator active outside transmit");
    AST_FE_LEAD: assert property ($rose(tx_busy) |-> !frontend_indicator_one [*2])
        else $error("indicator active at transmit entry");
    AST_TX_ENTRY: assert property ($rose(sleep_transmit_trigger) && pll_locked && !tx_busy |=> tx_busy)
        else $error("trigger did not start transmit");
    AST_MOD_TIME: assert property (mod_start |-> cnt_q == SETTLE_CYC)
        else $error("modulation start at wrong cycle");
    AST_TX_END: assert property (tx_done && tx_busy |=> !tx_busy)
        else $error("transmit did not end");
    AST_IRQ_IDLE: assert property (sel_n [*3] |-> irq_pin == $past(irq_pending))
        else $error("irq pin does not follow interrupts");
    // main scenarios reached
    COV_MOD: cover property (mod_start);
    COV_FLAG: cover property (!sel_n && irq_pin);
    COV_ANT: cover property (antenna_switch_out_one);
endmodule : rai_checker

bind rai_indicator_pins rai_checker #(.SETTLE_CYC(SETTLE_CYC)) rai_checker_i (.clk, .rst,
    .sel_n, .pll_locked, .sleep_transmit_trigger, .tx_done, .irq_pending, .tx_busy,
    .mod_start, .antenna_switch_out_one, .antenna_switch_out_two, .frontend_indicator_one,
    .frontend_indicator_two, .irq_pin);

// >>> verif/rai_host_model.sv
`timescale 1ns/1ps
module rai_host_model (
    // clock
    input  wire logic clk,
    // spi master pins
    output logic      sclk,
    output logic      sel_n,
    output logic      mosi,
    input  wire logic miso
);
    import rai_pkg::*;
    // bus idle: deselected, clock parked low
    initial begin
        sclk = 1'b0;
        sel_n = 1'b1;
        mosi = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // msb first; three clk per phase keeps sclk well under clk/4
    task automatic send_byte(input rai_byte_t b, output rai_byte_t q);
        for (int i = 7; i >= 0; i--) begin
            mosi = b[i];
            tick(3);
            q[i] = miso;
            sclk = 1'b1;
            tick(3);
            sclk = 1'b0;
        end
    endtask : send_byte
    task automatic open_access();
        tick(1);
        sel_n = 1'b0;
        tick(2);
    endtask : open_access
    // released data line flips so a stale level never passes for data
    task automatic close_access();
        tick(3);
        sel_n = 1'b1;
        mosi = ~mosi;
        tick(3);
    endtask : close_access
    task automatic reg_access(input rai_byte_t c, input rai_byte_t d, output rai_byte_t q);
        rai_byte_t skip;
        open_access();
        send_byte(c, skip);
        send_byte(d, q);
        close_access();
    endtask : reg_access
endmodule : rai_host_model

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import rai_pkg::*;
    localparam int SETTLE = 20;
    localparam int STEP = 2;
    logic clk, rst, pll_locked, sleep_transmit_trigger, tx_done, phr_valid, rx_frame_end;
    logic rx_error, irq_pending, fb_data_avail, miso, miso_oe, fb_pop, tx_busy, mod_start;
    logic antenna_switch_out_one, antenna_switch_out_two, irq_pin;
    logic frontend_indicator_one, frontend_indicator_two;
    wire logic sclk, sel_n, mosi;
    rai_byte_t fb_byte, r;
    int n_fail, total_checks, d0, d1, n_pop;
    wire logic [7:0] pins = {4'h0, antenna_switch_out_one, antenna_switch_out_two,
                             frontend_indicator_one, frontend_indicator_two};
    rai_indicator_pins #(.SETTLE_CYC(SETTLE), .STEP_CYC(STEP)) rai_indicator_pins_i (.clk,
        .rst, .sclk, .sel_n, .mosi, .miso, .miso_oe, .pll_locked, .sleep_transmit_trigger,
        .tx_done, .phr_valid, .rx_frame_end, .rx_error, .irq_pending, .fb_data_avail,
        .fb_byte, .fb_pop, .tx_busy, .mod_start, .antenna_switch_out_one,
        .antenna_switch_out_two, .frontend_indicator_one, .frontend_indicator_two, .irq_pin);
    rai_host_model rai_host_model_i (.clk, .sclk, .sel_n, .mosi, .miso);
    // bench clock, 50 ns period
    always #25 clk = ~clk;
    // buffer bytes taken, one per load of the shift register during a buffer read
    always @(posedge clk) if (fb_pop === 1'b1) n_pop++;
    ////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input rai_byte_t d);
        rai_host_model_i.reg_access({2'b11, a}, d, r);
    endtask : wr
    task automatic rd(input logic [5:0] a, input rai_byte_t e);
        rai_host_model_i.reg_access({2'b10, a}, 8'h00, r);
        chk(r, e);
    endtask : rd
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////
    task automatic t_reset();
        chk(pins, 8'h00);
        rd(6'h04, 8'h20);
        rd(6'h05, 8'h00);
        rd(6'h0d, 8'h03);
        rd(6'h3f, 8'h00);
        $display("reset values done");
    endtask : t_reset
    task automatic t_antenna();
        wr(6'h0d, 8'h06);
        chk(pins, 8'h08);
        wr(6'h0d, 8'h05);
        chk(pins, 8'h04);
        rd(6'h0d, 8'h85);
        wr(6'h0d, 8'h03);
        chk(pins, 8'h00);
        $display("antenna done");
    endtask : t_antenna
    // one transmit; returns entry-to-indicator cycles
    task automatic tx_run(output int dfe);
        int n, nb, dm;
        n = 0;
        nb = 0;
        dfe = 0;
        dm = 0;
        sleep_transmit_trigger = 1'b1;
        repeat (SETTLE + 8) begin
            tick(1);
            n++;
            if (tx_busy === 1'b1 && nb == 0) nb = n;
            if (frontend_indicator_one === 1'b1 && dfe == 0) dfe = n - nb;
            if (mod_start === 1'b1) dm = n - nb;
        end
        chk(8'(dm), 8'(SETTLE));
        chk(pins, 8'h02);
        sleep_transmit_trigger = 1'b0;
        pulse(tx_done);
        tick(2);
        chk(pins, 8'h01);
    endtask : tx_run
    task automatic t_frontend();
        wr(6'h04, 8'ha0);
        chk(pins, 8'h01);
        pll_locked = 1'b1;
        tx_run(d0);
        wr(6'h05, 8'h50);
        tx_run(d1);
        chk(8'(d0 - d1), 8'(2 * STEP));
        wr(6'h04, 8'h20);
        pll_locked = 1'b0;
        chk(pins, 8'h00);
        $display("front end done");
    endtask : t_frontend
    task automatic t_stamp();
        wr(6'h04, 8'h60);
        pulse(phr_valid);
        tick(2);
        chk(pins, 8'h04);
        tick(10);
        chk(pins, 8'h04);
        pulse(rx_frame_end);
        tick(3);
        chk(pins, 8'h00);
        wr(6'h04, 8'h20);
        pulse(phr_valid);
        tick(3);
        chk(pins, 8'h00);
        $display("time stamp done");
    endtask : t_stamp
    task automatic t_fbe();
        wr(6'h04, 8'h30);
        rai_host_model_i.open_access();
        rai_host_model_i.send_byte(8'h20, r);
        // still not ready about 750 ns after the last rise
        tick(12);
        chk({7'h0, irq_pin}, 8'h01);
        chk({7'h0, miso_oe}, 8'h01);
        tick(9);
        chk({7'h0, irq_pin}, 8'h00);
        irq_pending = 1'b1;
        tick(3);
        chk({7'h0, irq_pin}, 8'h00);
        fb_data_avail = 1'b0;
        tick(3);
        chk({7'h0, irq_pin}, 8'h01);
        fb_data_avail = 1'b1;
        pulse(rx_error);
        tick(3);
        chk({7'h0, irq_pin}, 8'h01);
        rai_host_model_i.close_access();
        chk({7'h0, irq_pin}, 8'h01);
        chk(8'(n_pop), 8'h01);
        irq_pending = 1'b0;
        tick(3);
        chk({7'h0, irq_pin}, 8'h00);
        $display("buffer flag done");
    endtask : t_fbe
    ////////////////////////////////////////
    // main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {pll_locked, sleep_transmit_trigger, tx_done, phr_valid} = 4'h0;
        {rx_frame_end, rx_error, irq_pending} = 3'h0;
        fb_data_avail = 1'b1;
        fb_byte = 8'h5a;
        n_fail = 0;
        total_checks = 0;
        n_pop = 0;
        tick(16);
        rst = 1'b0;
        tick(2);
        t_reset();
        t_antenna();
        t_frontend();
        t_stamp();
        t_fbe();
        wrap_up();
    end
    // hang guard, well beyond the roughly 1700 cycles the tests take
    initial begin
        repeat (30000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
endmodule : tb_top
